/* hw/oa_avg_ctrl.sv */
// Sequencer driving a one-shot converter and averaging ten samples
`timescale 1ns/1ns
`include "oa_defs.svh"

// Notes on behaviour
// - A conversion is started on each tick of a 5 ms period timer that finds the sequencer waiting; a tick while busy starts none.
// - The converter is set up for one-shot mode, one conversion per start.
// - The dedicated converter clock is chosen as conversion clock.
// - Conversions start by software trigger, not by a hardware trigger.
// - Only analog channel 0 is sampled, its port pin set as input.
// - A conversion begins by writing 1 to the conversion start bit.
// - The controller clears the done flag and adds the result to a sum.
// - A result strictly above the stored maximum replaces it.
// - A result strictly below the stored minimum replaces it.
// - Ten conversions are taken before a final value is computed.
// - The final value is sum less maximum and minimum, divided by eight.
module oa_avg_ctrl #(
    parameter int unsigned PERIOD_CYC = `OA_PERIOD_CYC,
    parameter int RES_W = 10,
    parameter int SUM_W = 16
) (
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic irq, // Level interrupt
    output logic [7:0] dev_addr, // Converter register address
    output logic [15:0] dev_wdata, // Converter write data
    output logic dev_wr, // Converter write strobe
    output logic dev_rd, // Converter read strobe
    input wire logic [15:0] dev_rdata // Converter read data, same cycle
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    oa_pkg::oa_state_t state_r, state_nxt;
    oa_tick_if tk ();
    logic [SUM_W-1:0] sum_r;
    logic [RES_W-1:0] max_r, min_r, final_r;
    logic [3:0] cnt_r;
    logic final_valid_r;
    logic [7:0] dev_addr_r, dev_addr_nxt;
    logic [15:0] dev_wdata_r, dev_wdata_nxt;
    logic run_r;
    logic [`OA_EV_W-1:0] status_r, irq_en_r, ev_w;
    logic [31:0] rdata_r;
    logic [7:0] ap_addr_r;
    logic ap_wr_r;

    // Low result bits of a converter word
    function automatic logic [RES_W-1:0] res_of(input logic [15:0] w);
        res_of = w[RES_W-1:0];
    endfunction

    // ------------------------------------------------------------
    // Period timer
    // ------------------------------------------------------------
    assign tk.run = run_r;

    oa_period_timer #(
        .PERIOD_CYC(PERIOD_CYC)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire done_w = dev_rdata[`OA_IRQCS_DONE];
    wire [RES_W-1:0] sample_w = res_of(dev_rdata);
    wire [SUM_W-1:0] sum_add_w = sum_r + SUM_W'(sample_w);
    wire [SUM_W-1:0] trim_w = sum_r - SUM_W'(max_r) - SUM_W'(min_r);
    wire [RES_W-1:0] mean_w = RES_W'(trim_w >> `OA_KEEP_SHIFT);
    wire last_w = (cnt_r == `OA_SAMPLES - 4'h1);

    // Next state; setup runs once after reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            oa_pkg::OA_S_CFG_MODE: state_nxt = oa_pkg::OA_S_CFG_PORT;
            oa_pkg::OA_S_CFG_PORT: state_nxt = oa_pkg::OA_S_WAIT_TICK;
            oa_pkg::OA_S_WAIT_TICK: begin
                if (tk.tick) begin
                    state_nxt = oa_pkg::OA_S_START;
                end
            end
            oa_pkg::OA_S_START: state_nxt = oa_pkg::OA_S_POLL;
            oa_pkg::OA_S_POLL: begin
                // Finish is seen by the flag the converter raises
                if (done_w) begin
                    state_nxt = oa_pkg::OA_S_CLR;
                end
            end
            oa_pkg::OA_S_CLR: state_nxt = oa_pkg::OA_S_READ;
            oa_pkg::OA_S_READ: begin
                state_nxt = last_w ? oa_pkg::OA_S_CALC
                                   : oa_pkg::OA_S_WAIT_TICK;
            end
            oa_pkg::OA_S_CALC: state_nxt = oa_pkg::OA_S_WAIT_TICK;
            default: state_nxt = oa_pkg::OA_S_CFG_MODE;
        endcase
    end

    // Converter address and data for the access of the next state
    always_comb begin
        dev_addr_nxt = `OA_DEV_CTRL0;
        dev_wdata_nxt = `OA_DEV_CLR_VAL;
        case (state_nxt)
            oa_pkg::OA_S_CFG_MODE: begin
                dev_addr_nxt = `OA_DEV_CTRL1;
                dev_wdata_nxt = `OA_DEV_CFG_VAL;
            end
            oa_pkg::OA_S_CFG_PORT: begin
                dev_addr_nxt = `OA_DEV_PORTDIR;
                dev_wdata_nxt = `OA_DEV_PORT_IN;
            end
            oa_pkg::OA_S_START: begin
                dev_addr_nxt = `OA_DEV_CTRL0;
                dev_wdata_nxt = `OA_DEV_START_VAL;
            end
            oa_pkg::OA_S_POLL: dev_addr_nxt = `OA_DEV_IRQCS;
            oa_pkg::OA_S_CLR: begin
                dev_addr_nxt = `OA_DEV_IRQCS;
                dev_wdata_nxt = `OA_DEV_CLR_VAL;
            end
            oa_pkg::OA_S_READ: dev_addr_nxt = `OA_DEV_RES0;
            default: dev_addr_nxt = `OA_DEV_CTRL0;
        endcase
    end

    // State and converter access registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= oa_pkg::OA_S_CFG_MODE;
            dev_addr_r <= `OA_DEV_CTRL1;
            dev_wdata_r <= `OA_DEV_CFG_VAL;
        end else begin
            state_r <= state_nxt;
            dev_addr_r <= dev_addr_nxt;
            dev_wdata_r <= dev_wdata_nxt;
        end
    end

    // Strobes follow the state; the start bit self-clears in the device
    assign dev_wr = (state_r == oa_pkg::OA_S_CFG_MODE)
                 || (state_r == oa_pkg::OA_S_CFG_PORT)
                 || (state_r == oa_pkg::OA_S_START)
                 || (state_r == oa_pkg::OA_S_CLR);
    assign dev_rd = (state_r == oa_pkg::OA_S_POLL)
                 || (state_r == oa_pkg::OA_S_READ);
    assign dev_addr = dev_addr_r;
    assign dev_wdata = dev_wdata_r;

    // Accumulate one sample, or close the group of ten
    always_ff @(posedge sys_clk) begin
        if (rst || state_r == oa_pkg::OA_S_CALC) begin
            sum_r <= '0;
            cnt_r <= 4'h0;
            max_r <= '0;
            min_r <= '1;
        end else if (state_r == oa_pkg::OA_S_READ) begin
            sum_r <= sum_add_w;
            cnt_r <= cnt_r + 4'h1;
            if (sample_w > max_r) max_r <= sample_w;
            if (sample_w < min_r) min_r <= sample_w;
        end
    end

    // Final value stays until the next group replaces it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            final_r <= '0;
            final_valid_r <= 1'b0;
        end else if (state_r == oa_pkg::OA_S_CALC) begin
            final_r <= mean_w;
            final_valid_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    // A tick while busy means the period is too short for the device
    assign ev_w[`OA_EV_FINAL] = (state_r == oa_pkg::OA_S_CALC);
    assign ev_w[`OA_EV_MISSED] = tk.tick
        && (state_r != oa_pkg::OA_S_WAIT_TICK);

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    wire ap_take_w = hsel && htrans[1] && hready;
    wire dp_wr_w = ap_wr_r;
    wire [`OA_EV_W-1:0] clr_w = (dp_wr_w && ap_addr_r == `OA_REG_CLEAR)
        ? hwdata[`OA_EV_W-1:0] : '0;
    wire [31:0] live_w = {20'h00000, cnt_r, 4'h0, 4'(state_r)};
    wire [31:0] result_w = {15'h0000, final_valid_r,
        16'(final_r)};

    // Read mux, latched at the address phase
    always_comb begin
        case (haddr[7:0])
            `OA_REG_CTRL: rdata_r = {31'h0000_0000, run_r};
            `OA_REG_STATUS: rdata_r = 32'(status_r);
            `OA_REG_IRQ_EN: rdata_r = 32'(irq_en_r);
            `OA_REG_RESULT: rdata_r = result_w;
            `OA_REG_LIVE: rdata_r = live_w;
            default: rdata_r = 32'h0000_0000;
        endcase
    end

    // Address phase capture and read data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ap_wr_r <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_wr_r <= ap_take_w && hwrite;
            ap_addr_r <= haddr[7:0];
            if (ap_take_w && !hwrite) hrdata <= rdata_r;
        end
    end

    // Control registers; a set in the clear cycle survives
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_r <= 1'b0;
            irq_en_r <= '0;
            status_r <= '0;
        end else begin
            if (dp_wr_w && ap_addr_r == `OA_REG_CTRL) begin
                run_r <= hwdata[`OA_CTRL_RUN];
            end
            if (dp_wr_w && ap_addr_r == `OA_REG_IRQ_EN) begin
                irq_en_r <= hwdata[`OA_EV_W-1:0];
            end
            status_r <= (status_r & ~clr_w) | ev_w;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(status_r & irq_en_r);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_tick_starts: assert property (
        state_r == oa_pkg::OA_S_WAIT_TICK && tk.tick
        |=> dev_wr && dev_addr == `OA_DEV_CTRL0
            && dev_wdata[`OA_CTRL0_START])
        else $error("tick did not start a conversion");

    chk_setup_once: assert property (
        $fell(state_r == oa_pkg::OA_S_CFG_MODE && dev_wr)
        |-> $past(dev_addr) == `OA_DEV_CTRL1
            && $past(dev_wdata) == `OA_DEV_CFG_VAL
            && dev_addr == `OA_DEV_PORTDIR
            && dev_wdata == `OA_DEV_PORT_IN)
        else $error("converter setup sequence wrong");

    chk_start_poll: assert property (
        state_r == oa_pkg::OA_S_START
        |-> dev_wr ##1 dev_rd && dev_addr == `OA_DEV_IRQCS)
        else $error("start write not followed by polling");

    chk_flag_clear: assert property (
        dev_rd && dev_addr == `OA_DEV_IRQCS && done_w
        |=> dev_wr && dev_addr == `OA_DEV_IRQCS
            && !dev_wdata[`OA_IRQCS_DONE]
            ##1 dev_rd && dev_addr == `OA_DEV_RES0)
        else $error("done flag not cleared before result read");

    chk_sum_adds: assert property (
        state_r == oa_pkg::OA_S_READ && !last_w
        |=> sum_r == $past(sum_r) + SUM_W'($past(sample_w)))
        else $error("sum did not take the sample");

    chk_max_keep: assert property (
        state_r == oa_pkg::OA_S_READ && !last_w
        |=> max_r == (($past(sample_w) > $past(max_r))
            ? $past(sample_w) : $past(max_r)))
        else $error("maximum tracked wrongly");

    chk_min_keep: assert property (
        state_r == oa_pkg::OA_S_READ && !last_w
        |=> min_r == (($past(sample_w) < $past(min_r))
            ? $past(sample_w) : $past(min_r)))
        else $error("minimum tracked wrongly");

    chk_ten_group: assert property (
        state_r == oa_pkg::OA_S_CALC
        |-> cnt_r == `OA_SAMPLES
            && $past(state_r) == oa_pkg::OA_S_READ)
        else $error("group size is not ten");

    chk_count_bound: assert property (
        cnt_r <= `OA_SAMPLES)
        else $error("sample count ran past ten");

    chk_final_mean: assert property (
        state_r == oa_pkg::OA_S_CALC
        |=> final_r == $past(mean_w) && final_valid_r
            && cnt_r == 4'h0 && sum_r == '0
            && status_r[`OA_EV_FINAL])
        else $error("final value or group reset wrong");
endmodule

/* hw/oa_defs.svh */
// Constants for the one-shot converter averaging controller
`ifndef OA_DEFS_SVH
`define OA_DEFS_SVH

// ----------------------------------------------------------------
// Clock and sampling period
// ----------------------------------------------------------------
`define OA_SYS_CLK_HZ 50000000
`define OA_PERIOD_US 5000
`define OA_PERIOD_CYC ((`OA_SYS_CLK_HZ / 1000000) * `OA_PERIOD_US)

// ----------------------------------------------------------------
// Converter register map, reached over the converter's own port
// ----------------------------------------------------------------
`define OA_DEV_CTRL0 8'h00
`define OA_DEV_CTRL1 8'h01
`define OA_DEV_IRQCS 8'h02
`define OA_DEV_RES0 8'h04
`define OA_DEV_PORTDIR 8'h08
`define OA_CTRL0_START 0
`define OA_IRQCS_DONE 0
// One-shot mode, converter clock, software trigger, channel 0
`define OA_DEV_CFG_VAL 16'h0004
// Port 1 bit 0 as input
`define OA_DEV_PORT_IN 16'h0000
`define OA_DEV_START_VAL 16'h0001
`define OA_DEV_CLR_VAL 16'h0000

// ----------------------------------------------------------------
// Averaging
// ----------------------------------------------------------------
`define OA_SAMPLES 4'hA
`define OA_KEEP_SHIFT 3

// ----------------------------------------------------------------
// Own register map on AHB-Lite (byte addresses)
// ----------------------------------------------------------------
`define OA_REG_CTRL 8'h00
`define OA_REG_STATUS 8'h04
`define OA_REG_CLEAR 8'h08
`define OA_REG_IRQ_EN 8'h0C
`define OA_REG_RESULT 8'h10
`define OA_REG_LIVE 8'h14
`define OA_CTRL_RUN 0
`define OA_EV_FINAL 0
`define OA_EV_MISSED 1
`define OA_EV_W 2
`define OA_RESULT_VALID 16

`endif

/* hw/oa_pkg.sv */
// Types shared by the averaging controller
package oa_pkg;
    typedef enum logic [3:0] {
        OA_S_CFG_MODE = 4'b0000,
        OA_S_CFG_PORT = 4'b0001,
        OA_S_WAIT_TICK = 4'b0010,
        OA_S_START = 4'b0011,
        OA_S_POLL = 4'b0100,
        OA_S_CLR = 4'b0101,
        OA_S_READ = 4'b0110,
        OA_S_CALC = 4'b0111
    } oa_state_t;
endpackage

/* hw/oa_tick_if.sv */
// Link between the sequencer and its period timer
`timescale 1ns/1ns
interface oa_tick_if;
    logic run;
    logic tick;
    modport timer (input run, output tick);
    modport ctrl (output run, input tick);
endinterface

/* hw/oa_period_timer.sv */
// Period timer, counting only while running, giving one tick pulse per sampling period
`timescale 1ns/1ns
`include "oa_defs.svh"
module oa_period_timer #(
    parameter int unsigned PERIOD_CYC = `OA_PERIOD_CYC
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, high
    oa_tick_if.timer tk // Run in, tick out
);
    logic [31:0] cnt_r;
    logic tick_r;
    wire last_w = (cnt_r == 32'(PERIOD_CYC - 1));

    // Count only while running; restart from zero when stopped
    always_ff @(posedge sys_clk) begin
        if (rst || !tk.run) begin
            cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= last_w ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
            tick_r <= last_w;
        end
    end

    assign tk.tick = tick_r;
endmodule

/* bench/oa_conv_model.sv */
// Behavioural one-shot converter answering the controller's register port
`timescale 1ns/1ns
module oa_conv_model (
    sys_clk, // System clock
    rst, // Synchronous reset, high
    dev_addr, // Register address
    dev_wdata, // Write data
    dev_wr, // Write strobe
    dev_rd, // Read strobe
    dev_rdata // Read data, same cycle
);
    input wire logic sys_clk;
    input wire logic rst;
    input wire logic [7:0] dev_addr;
    input wire logic [15:0] dev_wdata;
    input wire logic dev_wr;
    input wire logic dev_rd;
    output logic [15:0] dev_rdata;
    // Analog levels, one taken per conversion
    logic [9:0] src_q[$];
    int conv_cyc = 3;
    int n_conv = 0;
    int cyc = 0;
    int last_start = 0;
    int last_gap = 0;
    logic [15:0] cfg_r = 16'hFFFF;
    logic [15:0] dir_r = 16'hFFFF;
    logic busy_r = 1'b0;
    logic done_r = 1'b0;
    logic [9:0] res_r = 10'h000;
    logic [9:0] smp_r = 10'h000;
    int cnt = 0;
    // ------------------------------------------------------------
    // Read path: released bus shows a changing pattern, not a stale value
    // ------------------------------------------------------------
    always_comb begin
        if (!dev_rd)
            dev_rdata = cyc[15:0] ^ 16'hA5C3;
        else if (dev_addr == 8'h00)
            dev_rdata = {15'h0000, busy_r};
        else if (dev_addr == 8'h02)
            dev_rdata = {15'h0000, done_r};
        else if (dev_addr == 8'h04)
            dev_rdata = {6'h00, res_r};
        else
            dev_rdata = 16'h0000;
    end
    // ------------------------------------------------------------
    // Register writes and conversion timing
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (busy_r && cnt == 0) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            res_r <= smp_r;
            n_conv <= n_conv + 1;
        end else if (busy_r)
            cnt <= cnt - 1;
        if (dev_wr && dev_addr == 8'h01)
            cfg_r <= dev_wdata;
        if (dev_wr && dev_addr == 8'h08)
            dir_r <= dev_wdata;
        if (dev_wr && dev_addr == 8'h02 && !dev_wdata[0])
            done_r <= 1'b0;
        if (dev_wr && dev_addr == 8'h00 && dev_wdata[0]) begin
            busy_r <= 1'b1;
            cnt <= conv_cyc;
            smp_r <= (src_q.size() > 0) ? src_q.pop_front() : 10'h000;
            last_gap <= cyc - last_start;
            last_start <= cyc;
        end
        // Reset drops any conversion in flight and its flag
        if (rst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
    end
endmodule

/* bench/oa_avg_ctrl_bench.sv */
// Self-checking bench for the averaging controller
`timescale 1ns/1ns
`include "oa_defs.svh"
module oa_avg_ctrl_bench;
    localparam int PER = 50;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready;
    logic [31:0] hrdata;
    logic hresp, irq, dev_wr, dev_rd;
    logic [7:0] dev_addr;
    logic [15:0] dev_wdata, dev_rdata;
    logic [31:0] exp_q[$];
    logic rd_dp = 1'b0;
    logic [9:0] g[0:9];
    logic [31:0] exp1, exp2;
    int n_mismatch = 0;
    int n_compared = 0;
    int k;
    always #10 sys_clk = ~sys_clk;
    oa_avg_ctrl #(.PERIOD_CYC(PER)) DUT (.sys_clk(sys_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .irq(irq), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_rdata(dev_rdata));
    oa_conv_model PM (.sys_clk(sys_clk), .rst(rst), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_rdata(dev_rdata));
    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Interrupt level, looked at one edge after the write that moves it
    task automatic chk_irq(input logic e);
        @(posedge sys_clk);
        chk(32'(irq), 32'(e));
    endtask
    // Watcher: read data stands in the data phase, oldest note first
    always @(posedge sys_clk) begin
        if (rd_dp)
            chk(hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end
    // ------------------------------------------------------------
    // AHB-Lite master: hold each phase until hready is seen high
    // ------------------------------------------------------------
    task automatic ahb(input logic [7:0] a, input logic wr,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0000_0000;
        if (!wr)
            exp_q.push_back(d);
        do @(posedge sys_clk); while (hready !== 1'b1);
    endtask
    // Mean of ten with the extremes dropped, truncating
    function automatic logic [31:0] mean8();
        logic [15:0] s, mx, mn;
        s = 16'h0000;
        mx = 16'h0000;
        mn = 16'hFFFF;
        for (int i = 0; i < 10; i++) begin
            s = s + g[i];
            if (g[i] > mx) mx = g[i];
            if (g[i] < mn) mn = g[i];
        end
        s = (s - mx - mn) >> 3;
        return 32'h0001_0000 | {22'h000000, s[9:0]};
    endfunction
    task automatic fill(input int first);
        for (int i = 0; i < 10; i++) begin
            g[i] = (first && i == 0) ? 10'h3FF : (first && i == 1) ?
                10'h000 : 10'($urandom & 32'h0000_03FF);
            PM.src_q.push_back(g[i]);
        end
    endtask
    task automatic wait_conv(input int n);
        k = 0;
        while (PM.n_conv < n && k < 3000) begin
            @(posedge sys_clk);
            k++;
        end
        // A converter that never finishes counts as a failure
        if (k >= 3000) begin
            n_mismatch++;
            test_done();
        end
        repeat (10) @(posedge sys_clk);
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hCA3C670E));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // Reset values, unmapped and write-only places read zero
        ahb(`OA_REG_CTRL, 0, 32'h0);
        ahb(`OA_REG_STATUS, 0, 32'h0);
        ahb(`OA_REG_RESULT, 0, 32'h0);
        ahb(`OA_REG_IRQ_EN, 0, 32'h0);
        ahb(`OA_REG_CLEAR, 0, 32'h0);
        ahb(8'h20, 1, 32'hFFFF_FFFF);
        ahb(8'h20, 0, 32'h0);
        chk(32'(PM.cfg_r), 32'h0004);
        chk(32'(PM.dir_r), 32'h0000);
        // Group one: random levels, prompt converter
        fill(0);
        exp1 = mean8();
        fill(1);
        exp2 = mean8();
        ahb(`OA_REG_IRQ_EN, 1, 32'h3);
        ahb(`OA_REG_CTRL, 1, 32'h1);
        ahb(`OA_REG_CTRL, 0, 32'h1);
        wait_conv(10);
        chk_irq(1'b1);
        ahb(`OA_REG_RESULT, 0, exp1);
        ahb(`OA_REG_LIVE, 0, 32'h2);
        ahb(`OA_REG_STATUS, 0, 32'h1);
        chk(32'(PM.last_gap), 32'(PER));
        ahb(`OA_REG_CLEAR, 1, 32'h1);
        ahb(`OA_REG_STATUS, 0, 32'h0);
        chk_irq(1'b0);
        // Group two: slow converter, extremes, interrupt masked
        ahb(`OA_REG_IRQ_EN, 1, 32'h0);
        PM.conv_cyc = 20;
        wait_conv(20);
        chk_irq(1'b0);
        ahb(`OA_REG_STATUS, 0, 32'h1);
        ahb(`OA_REG_RESULT, 0, exp2);
        ahb(`OA_REG_IRQ_EN, 1, 32'h3);
        chk_irq(1'b1);
        ahb(`OA_REG_CLEAR, 1, 32'h3);
        chk_irq(1'b0);
        // Conversion longer than the period: a tick is missed
        PM.conv_cyc = 80;
        wait_conv(21);
        repeat (PER) @(posedge sys_clk);
        ahb(`OA_REG_STATUS, 0, 32'h2);
        chk_irq(1'b1);
        ahb(`OA_REG_CTRL, 1, 32'h0);
        test_done();
    end
endmodule
